/* File: bpwo_defines.svh */
/*
  Register offsets, field positions, reset values and timing counts for the parallel
  decimal weight output port. Assumes a 100 MHz system clock and a 32-bit AHB-Lite slave.
*/
`ifndef BPWO_DEFINES_SVH
`define BPWO_DEFINES_SVH

`define BPWO_CLK_MHZ        100
`define BPWO_CTL_MIN_MS     100
// Filter length: more than 100 ms at 100 MHz
`define BPWO_CTL_MIN_CYC    (`BPWO_CTL_MIN_MS * 1000 * `BPWO_CLK_MHZ)
`define BPWO_STROBE_CYC     100000

`define BPWO_ADDR_CTRL      8'h00
`define BPWO_ADDR_VALUE     8'h04
`define BPWO_ADDR_STATUS    8'h08
`define BPWO_ADDR_IRQ_STAT  8'h0C
`define BPWO_ADDR_IRQ_MASK  8'h10

`define BPWO_CTRL_MEAS      0
`define BPWO_CTRL_NEG       1
`define BPWO_CTRL_ERR       2
`define BPWO_CTRL_OVR       3
`define BPWO_CTRL_GROSS     4
`define BPWO_CTRL_STABLE    5
`define BPWO_CTRL_DP_LO     8
`define BPWO_CTRL_DP_W      4
`define BPWO_CTRL_RESET     32'h0000_0000

`define BPWO_IRQ_CONV       0
`define BPWO_IRQ_STROBE     1
`define BPWO_IRQ_HOLD       2
`define BPWO_IRQ_OE         3
`define BPWO_IRQ_W          4

`endif

/* File: bpwo_pkg.sv */
/*
  Types for the parallel decimal weight output port.
  Assumes bpwo_defines.svh carries all numbers.
*/
package bpwo_pkg;
  typedef enum logic [1:0]
  {
    STB_IDLE,
    STB_PULSE
  } bpwo_strobe_t;
endpackage

/* File: bpwo_level_filter.sv */
/*
  Synchronises one external level input and accepts a new level only after it has stood
  unchanged for more than MIN_CYC cycles. Assumes an asynchronous pin input.
*/
`timescale 1ns/1ps
module bpwo_level_filter
#(
  parameter int unsigned MIN_CYC = 10
)
(
  input  wire logic ref_clk,
  input  wire logic arst_n,
  input  wire logic pinIn,
  output logic      level
);
  localparam int CW = $clog2(MIN_CYC + 2);

  logic          syncA;
  logic          syncB;
  logic [CW-1:0] count;

  initial
  begin
    if (MIN_CYC < 1)
      $error("MIN_CYC must be at least 1");
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      syncA <= 1'b0;
      syncB <= 1'b0;
    end
    else
    begin
      syncA <= pinIn;
      syncB <= syncA;
    end
  end

  // Shorter pulses never reach the accepted level
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      count <= '0;
      level <= 1'b0;
    end
    else if (syncB == level)
      count <= '0;
    else if (count == CW'(MIN_CYC))
    begin
      level <= syncB;
      count <= '0;
    end
    else
      count <= count + 1'b1;
  end
endmodule

/* File: bpwo_top.sv */
/*
  Parallel decimal weight output port with an AHB-Lite register slave and interrupt.
  Assumes software posts each new conversion by writing VALUE; pins are open collector,
  an output bit of 1 means the transistor is on.
*/
// Notes on behaviour
// - The weight appears as eight parallel decimal digits plus a separate sign line.
// - Sign is on for a negative value and off for a positive one.
// - After each finished conversion in measurement mode without error or over range the print strobe is on for a fixed time, then off.
// - The error flag is on whenever any error condition is present in measurement mode.
// - The gross flag is on while the digits carry gross weight, off otherwise.
// - Outside measurement mode every output of the port is off.
// - While hold is active the digit outputs stay frozen.
// - While the output-enable control is active every port output is floated off.
// - Hold and output-enable are levels accepted only after more than 100 ms.
// - A logical one on digit, strobe and sign lines turns the transistor on.
// - Over range turns the over flag on and digits, strobe and sign off.
// - An error turns the error flag on and digits, strobe and sign off.
// - While hold is active no new strobe starts.
// - A strobe already running when hold arrives finishes, then stays off.
`timescale 1ns/1ps
`include "bpwo_defines.svh"
module bpwo_top
#(
  parameter int unsigned DIGITS     = 8,
  parameter int unsigned STROBE_CYC = `BPWO_STROBE_CYC,
  parameter int unsigned CTL_CYC    = `BPWO_CTL_MIN_CYC
)
(
  input  wire logic               ref_clk,
  input  wire logic               arst_n,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic                    irq,
  input  wire logic               holdPin,
  input  wire logic               outDisablePin,
  output logic      [DIGITS*4-1:0] digitOut,
  output logic      [DIGITS*4-1:0] digitOe,
  output logic                    sign_out,
  output logic                    signOe,
  output logic                    printStrobe,
  output logic                    printStrobeOe,
  output logic                    errorFlag,
  output logic                    errorOe,
  output logic                    over_range_flag,
  output logic                    overOe,
  output logic                    stableFlag,
  output logic                    stableOe,
  output logic                    grossFlag,
  output logic                    grossOe,
  output logic      [3:0]         pointOut,
  output logic      [3:0]         pointOe
);
  localparam int DW = DIGITS * 4;
  localparam int SW = $clog2(STROBE_CYC + 1);

  initial
  begin
    if (DIGITS != 8)
      $error("DIGITS must be 8 to fit one register word");
    if (STROBE_CYC < 1)
      $error("STROBE_CYC must be at least 1");
  end

  function automatic logic wordHit(input logic [7:0] a, input logic [7:0] reg_addr);
    wordHit = (a[7:2] == reg_addr[7:2]);
  endfunction

  logic [31:0]             ctrl;
  logic [DW-1:0]           value;
  logic [`BPWO_IRQ_W-1:0]  irqStat;
  logic [`BPWO_IRQ_W-1:0]  irqMask;
  logic                    dpWrite;
  logic [7:0]              dpAddr;
  logic                    convPulse;
  logic                    holdLvl;
  logic                    oeLvl;
  logic                    holdLvlD;
  logic                    oeLvlD;
  logic [DW-1:0]           heldDigits;
  logic                    heldNeg;
  logic                    pendConv;
  logic [SW-1:0]           stbCount;
  bpwo_pkg::bpwo_strobe_t  stbState;
  logic                    strobeOn;
  logic                    strobeDone;
  logic                    measMode;
  logic                    blankData;
  logic [`BPWO_IRQ_W-1:0]  irqSet;
  logic                    addrTaken;
  logic                    dataSettled;

  bpwo_level_filter #(.MIN_CYC(CTL_CYC)) u_hold_filter
  (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .pinIn   (holdPin),
    .level   (holdLvl)
  );

  bpwo_level_filter #(.MIN_CYC(CTL_CYC)) u_oe_filter
  (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .pinIn   (outDisablePin),
    .level   (oeLvl)
  );

  // AHB-Lite: zero wait states, always OKAY
  assign addrTaken = hsel && hready && htrans[1];

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dpWrite <= 1'b0;
      dpAddr  <= 8'h00;
    end
    else if (hready)
    begin
      dpWrite <= addrTaken && hwrite;
      dpAddr  <= haddr[7:0];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addrTaken && !hwrite)
      begin
        if (wordHit(haddr[7:0], `BPWO_ADDR_CTRL))
          hrdata <= ctrl;
        else if (wordHit(haddr[7:0], `BPWO_ADDR_VALUE))
          hrdata <= value;
        else if (wordHit(haddr[7:0], `BPWO_ADDR_STATUS))
          hrdata <= {26'h0, strobeOn, pendConv, holdLvl, oeLvl, measMode, blankData};
        else if (wordHit(haddr[7:0], `BPWO_ADDR_IRQ_STAT))
          hrdata <= {28'h0, irqStat};
        else if (wordHit(haddr[7:0], `BPWO_ADDR_IRQ_MASK))
          hrdata <= {28'h0, irqMask};
        else
          hrdata <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      ctrl <= `BPWO_CTRL_RESET;
    else if (dpWrite && wordHit(dpAddr, `BPWO_ADDR_CTRL))
      ctrl <= hwdata;
  end

  // Writing VALUE marks a finished conversion
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      value     <= '0;
      convPulse <= 1'b0;
    end
    else
    begin
      convPulse <= dpWrite && wordHit(dpAddr, `BPWO_ADDR_VALUE);
      if (dpWrite && wordHit(dpAddr, `BPWO_ADDR_VALUE))
        value <= hwdata[DW-1:0];
    end
  end

  assign measMode  = ctrl[`BPWO_CTRL_MEAS];
  assign blankData = ctrl[`BPWO_CTRL_OVR] || ctrl[`BPWO_CTRL_ERR];

  // Digits latch only between strobes so they never move under a pulse
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      heldDigits <= '0;
      heldNeg    <= 1'b0;
      pendConv   <= 1'b0;
    end
    else if (!holdLvl && !strobeOn)
    begin
      heldDigits <= value;
      heldNeg    <= ctrl[`BPWO_CTRL_NEG];
      pendConv   <= convPulse || pendConv;
      if (stbState == bpwo_pkg::STB_IDLE && pendConv && dataSettled)
        pendConv <= convPulse;
    end
    // Conversion during hold waits, strobed once hold drops
    else if (convPulse)
      pendConv <= 1'b1;
  end

  // Strobe: started one cycle after latch, so data settle first
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stbState   <= bpwo_pkg::STB_IDLE;
      stbCount   <= '0;
      strobeDone <= 1'b0;
    end
    else
    begin
      strobeDone <= 1'b0;
      case (stbState)
        bpwo_pkg::STB_IDLE:
        begin
          if (pendConv && dataSettled && !holdLvl && !blankData && measMode)
          begin
            stbState <= bpwo_pkg::STB_PULSE;
            stbCount <= SW'(STROBE_CYC - 1);
          end
        end
        bpwo_pkg::STB_PULSE:
        begin
          // Hold does not cut a running pulse short
          if (stbCount == '0)
          begin
            stbState   <= bpwo_pkg::STB_IDLE;
            strobeDone <= 1'b1;
          end
          else
            stbCount <= stbCount - 1'b1;
        end
        default:
          stbState <= bpwo_pkg::STB_IDLE;
      endcase
    end
  end

  assign strobeOn = (stbState == bpwo_pkg::STB_PULSE);

  // Pin drivers: 1 = transistor on; enable low floats the pin
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      digitOut        <= '0;
      sign_out        <= 1'b0;
      printStrobe     <= 1'b0;
      errorFlag       <= 1'b0;
      over_range_flag <= 1'b0;
      stableFlag      <= 1'b0;
      grossFlag       <= 1'b0;
      pointOut        <= 4'h0;
    end
    else if (!measMode)
    begin
      digitOut        <= '0;
      sign_out        <= 1'b0;
      printStrobe     <= 1'b0;
      errorFlag       <= 1'b0;
      over_range_flag <= 1'b0;
      stableFlag      <= 1'b0;
      grossFlag       <= 1'b0;
      pointOut        <= 4'h0;
    end
    else
    begin
      digitOut        <= blankData ? '0 : heldDigits;
      sign_out        <= !blankData && heldNeg;
      printStrobe     <= !blankData && strobeOn;
      errorFlag       <= ctrl[`BPWO_CTRL_ERR];
      over_range_flag <= ctrl[`BPWO_CTRL_OVR];
      stableFlag      <= ctrl[`BPWO_CTRL_STABLE];
      grossFlag       <= ctrl[`BPWO_CTRL_GROSS];
      pointOut        <= ctrl[`BPWO_CTRL_DP_LO +: `BPWO_CTRL_DP_W];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      digitOe       <= '0;
      signOe        <= 1'b0;
      printStrobeOe <= 1'b0;
      errorOe       <= 1'b0;
      overOe        <= 1'b0;
      stableOe      <= 1'b0;
      grossOe       <= 1'b0;
      pointOe       <= 4'h0;
    end
    else
    begin
      digitOe       <= {DW{!oeLvl}};
      signOe        <= !oeLvl;
      printStrobeOe <= !oeLvl;
      errorOe       <= !oeLvl;
      overOe        <= !oeLvl;
      stableOe      <= !oeLvl;
      grossOe       <= !oeLvl;
      pointOe       <= {4{!oeLvl}};
    end
  end

  // Interrupt events
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      holdLvlD <= 1'b0;
      oeLvlD   <= 1'b0;
      dataSettled <= 1'b0;
    end
    else
    begin
      holdLvlD <= holdLvl;
      oeLvlD   <= oeLvl;
      // Latch ran last cycle, so pins settle before a strobe starts
      dataSettled <= !holdLvl && !strobeOn;
    end
  end

  assign irqSet = {oeLvl && !oeLvlD, holdLvl && !holdLvlD, strobeDone, convPulse};

  // Set wins over a same-cycle write-one clear
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irqStat <= '0;
      irqMask <= '0;
      irq     <= 1'b0;
    end
    else
    begin
      if (dpWrite && wordHit(dpAddr, `BPWO_ADDR_IRQ_STAT))
        irqStat <= (irqStat & ~hwdata[`BPWO_IRQ_W-1:0]) | irqSet;
      else
        irqStat <= irqStat | irqSet;
      if (dpWrite && wordHit(dpAddr, `BPWO_ADDR_IRQ_MASK))
        irqMask <= hwdata[`BPWO_IRQ_W-1:0];
      irq <= |(irqStat & irqMask);
    end
  end
endmodule

/* File: bpwo_chk.sv */
/* Port checker for bpwo_top: strobe, blanking, hold and disable timing.
   Assumes the short simulation counts handed on by the bind. */
`timescale 1ns/1ps
module bpwo_chk
#(
  parameter int unsigned DIGITS     = 8,
  parameter int unsigned STROBE_CYC = 8,
  parameter int unsigned CTL_CYC    = 20
)
(
  input wire logic                ref_clk,
  input wire logic                arst_n,
  input wire logic                hsel,
  input wire logic [31:0]         haddr,
  input wire logic [1:0]          htrans,
  input wire logic                hwrite,
  input wire logic                hready,
  input wire logic                holdPin,
  input wire logic                outDisablePin,
  input wire logic [DIGITS*4-1:0] digitOut,
  input wire logic [DIGITS*4-1:0] digitOe,
  input wire logic                sign_out,
  input wire logic                signOe,
  input wire logic                printStrobe,
  input wire logic                printStrobeOe,
  input wire logic                errorFlag,
  input wire logic                over_range_flag
);
  int   holdCnt;
  int   disCnt;
  int   stbCnt;
  logic valueWr;
  assign valueWr = hsel && hready && htrans[1] && hwrite && haddr == 32'h0000_0004;
  // Saturating hold and disable run lengths, so long holds never wrap
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      holdCnt <= 0;
      disCnt  <= 0;
      stbCnt  <= 0;
    end
    else
    begin
      holdCnt <= holdPin ? holdCnt + int'(holdCnt < 4000) : 0;
      disCnt  <= outDisablePin ? disCnt + int'(disCnt < 4000) : 0;
      stbCnt  <= printStrobe ? stbCnt + 1 : 0;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  a_strobe_length: assert property ($fell(printStrobe) |-> stbCnt == STROBE_CYC)
    else $error("print strobe length wrong");
  a_strobe_start: assert property (valueWr && holdCnt == 0 && !printStrobe && !errorFlag && !over_range_flag && printStrobeOe |-> ##[5:6] printStrobe)
    else $error("no strobe after conversion");
  a_blank_over: assert property (over_range_flag |-> digitOut == '0 && !sign_out && !printStrobe)
    else $error("outputs on while over range");
  a_blank_error: assert property (errorFlag |-> digitOut == '0 && !sign_out && !printStrobe)
    else $error("outputs on during error");
  a_float_all: assert property (disCnt > CTL_CYC + 6 |-> digitOe == '0 && !signOe && !printStrobeOe)
    else $error("port still driven while disabled");
  a_filter_min: assert property ($fell(signOe) |-> disCnt > CTL_CYC)
    else $error("short disable pulse accepted");
  a_hold_freeze: assert property (holdCnt > CTL_CYC + 6 |-> $stable(digitOut))
    else $error("digits moved during hold");
  a_hold_nostrobe: assert property (holdCnt > CTL_CYC + 6 && !$past(printStrobe) |-> !printStrobe)
    else $error("strobe started during hold");
  a_strobe_data: assert property (printStrobe |-> $stable(digitOut) && $stable(sign_out))
    else $error("data changed under strobe");
  c_strobe: cover property ($rose(printStrobe));
  c_float: cover property (disCnt > CTL_CYC + 6 && digitOe == '0);
  c_hold_strobe: cover property (holdCnt > CTL_CYC + 6 && printStrobe);
endmodule
bind bpwo_top bpwo_chk #(.DIGITS(DIGITS), .STROBE_CYC(STROBE_CYC), .CTL_CYC(CTL_CYC)) chk (.ref_clk, .arst_n,
  .hsel, .haddr, .htrans, .hwrite, .hready, .holdPin, .outDisablePin, .digitOut, .digitOe, .sign_out, .signOe,
  .printStrobe, .printStrobeOe, .errorFlag, .over_range_flag);

/* File: bpwo_plc.sv */
/* External controller model: drives hold and disable levels, reads digit lines.
   Assumes open collector lines with pull-ups; an undriven line reads as off. */
`timescale 1ns/1ps
module bpwo_plc
#(
  parameter int unsigned MIN_CYC = 20
)
(
  input  wire logic        ref_clk,
  input  wire logic        holdReq,
  input  wire logic        disReq,
  input  wire logic        glitch,
  input  wire logic [31:0] digitOut,
  input  wire logic [31:0] digitOe,
  output logic             holdPin,
  output logic             outDisablePin,
  output logic [31:0]      seenDigits
);
  int holdAge = 0;
  int disAge  = 0;
  int glitchLeft = 0;
  assign seenDigits = digitOut & digitOe;
  // Levels stretched past the minimum; glitch breaks that on purpose
  assign holdPin = holdReq || (holdAge != 0 && holdAge <= MIN_CYC + 4);
  assign outDisablePin = disReq || (disAge != 0 && disAge <= MIN_CYC + 4) || glitchLeft != 0;
  always @(posedge ref_clk)
  begin
    holdAge <= holdPin ? holdAge + 1 : 0;
    disAge <= (disReq || disAge != 0) && outDisablePin ? disAge + 1 : 0;
    glitchLeft <= glitch ? 5 : (glitchLeft != 0 ? glitchLeft - 1 : 0);
  end
endmodule

/* File: bcd_parallel_weight_output_bench.sv */
/* Self-checking bench for the parallel weight output port.
   Assumes a one-cycle data phase and short simulation counts. */
`timescale 1ns/1ps
module bcd_parallel_weight_output_bench;
  logic        ref_clk, arst_n, hsel, hwrite, hready, hreadyout, hresp, irq, holdPin, outDisablePin;
  logic        sign_out, signOe, printStrobe, printStrobeOe, errorFlag, errorOe, over_range_flag, overOe;
  logic        stableFlag, stableOe, grossFlag, grossOe, holdReq, disReq, glitch;
  logic [31:0] haddr, hwdata, hrdata, digitOut, digitOe, seenDigits;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  pointOut, pointOe;
  int          num_errors, comparisons, mCtrl, mVal, rdv, v2;
  assign hready = hreadyout;
  initial
  begin
    ref_clk = 0;
    forever #5 ref_clk = ~ref_clk;
  end
  bpwo_top #(.STROBE_CYC(8), .CTL_CYC(20)) dut (.ref_clk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .irq, .holdPin, .outDisablePin, .digitOut, .digitOe,
    .sign_out, .signOe, .printStrobe, .printStrobeOe, .errorFlag, .errorOe, .over_range_flag, .overOe,
    .stableFlag, .stableOe, .grossFlag, .grossOe, .pointOut, .pointOe);
  bpwo_plc #(.MIN_CYC(20)) plc (.ref_clk, .holdReq, .disReq, .glitch, .digitOut, .digitOe, .holdPin,
    .outDisablePin, .seenDigits);
  task automatic test_done();
    if (num_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic waitRdy();
    int n;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      num_errors++;
      test_done();
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input int d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    waitRdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy();
    rdv = hrdata;
  endtask
  task automatic strobe(input int exp);
    int n, w;
    n = 0;
    w = 0;
    while (printStrobe !== 1'b1 && w < 40)
    begin
      @(posedge ref_clk);
      w++;
    end
    while (printStrobe === 1'b1 && n < 40)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk("strobe", n, exp);
  endtask
  task automatic cmpOut();
    int ok;
    ok = (mCtrl & 1) && !(mCtrl & 12);
    chk("digits", seenDigits, ok ? mVal : 0);
    chk("sign", sign_out, ok && (mCtrl & 2));
    chk("error", errorFlag, (mCtrl & 5) == 5);
    chk("over", over_range_flag, (mCtrl & 9) == 9);
    chk("gross", grossFlag, (mCtrl & 17) == 17);
    chk("stable", stableFlag, (mCtrl & 33) == 33);
    chk("points", pointOut, (mCtrl & 1) ? (mCtrl >> 8) & 15 : 0);
  endtask
  task automatic newValue();
    int i;
    mVal = 0;
    for (i = 0; i < 8; i++)
      mVal |= ($urandom % 10) << (4 * i);
    bus(1, 8'h04, mVal);
  endtask
  task automatic oes(input logic [31:0] e);
    chk("oe", digitOe, e);
    chk("oes", {signOe, printStrobeOe, errorOe, overOe, stableOe, grossOe, pointOe}, e & 32'h3FF);
  endtask
  initial
  begin
    {arst_n, hsel, hwrite, holdReq, disReq, glitch, haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    num_errors = 0;
    comparisons = 0;
    void'($urandom(41));
    cyc(4);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    bus(0, 8'h00, 0);
    chk("ctrl", rdv, 0);
    bus(0, 8'h20, 0);
    chk("unmapped", rdv, 0);
    chk("resp", hresp, 0);
    for (int s = 0; s < 2; s++)
    begin
      mCtrl = 32'h531 | (s << 1);
      bus(1, 8'h00, mCtrl);
      newValue();
      strobe(8);
      cmpOut();
      oes(32'hFFFFFFFF);
    end
    for (int b = 2; b < 4; b++)
    begin
      mCtrl = 32'h531 | (1 << b);
      bus(1, 8'h00, mCtrl);
      cyc(4);
      cmpOut();
    end
    mCtrl = 32'h531;
    bus(1, 8'h00, mCtrl);
    holdReq <= 1'b1;
    cyc(14);
    newValue();
    strobe(8);
    cyc(10);
    v2 = mVal;
    newValue();
    rdv = mVal;
    mVal = v2;
    v2 = rdv;
    strobe(0);
    cmpOut();
    holdReq <= 1'b0;
    mVal = v2;
    strobe(8);
    cmpOut();
    disReq <= 1'b1;
    cyc(30);
    oes(0);
    disReq <= 1'b0;
    cyc(30);
    glitch <= 1'b1;
    @(posedge ref_clk);
    glitch <= 1'b0;
    cyc(30);
    oes(32'hFFFFFFFF);
    bus(1, 8'h10, 1);
    bus(1, 8'h0C, 15);
    newValue();
    strobe(8);
    chk("irq", irq, 1);
    bus(0, 8'h0C, 0);
    chk("stat", rdv & 3, 3);
    bus(1, 8'h0C, 1);
    cyc(3);
    chk("irqMasked", irq, 0);
    bus(1, 8'h10, 2);
    cyc(3);
    chk("irqEnd", irq, 1);
    bus(1, 8'h0C, 2);
    cyc(3);
    chk("irqClr", irq, 0);
    mCtrl = 32'h532;
    bus(1, 8'h00, mCtrl);
    cyc(4);
    cmpOut();
    test_done();
  end
endmodule
